// *** bench/dual_dac_host_assertions.sv ***
// concurrent checks on the host controller pins
`timescale 1ns/1ps
module dual_dac_host_assertions (
   // clock and reset
   input wire clk_sys, srst,
   // byte pins
   input wire select_n, write_n, latch_sel_hi, latch_sel_lo, output_update_n,
   input wire [3:0] bus_upper_nibble, bus_lower_nibble,
   // word pins
   input wire select_chan_a_n, select_chan_b_n, word_write_n, word_msb,
   input wire [10:0] word_low_bits
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   rst_idle_a: assert property ($fell(srst) |-> write_n && output_update_n && word_write_n)
      else $error("pins not idle after reset");
   wr_sel_a: assert property (!write_n |-> !select_n)
      else $error("strobe without select");
   wr_width_a: assert property ($fell(write_n) |-> ##19 !write_n ##1 write_n)
      else $error("write strobe width");
   addr_hold_a: assert property (!write_n |=> $stable({latch_sel_hi, latch_sel_lo, bus_lower_nibble}))
      else $error("address or data moved");
   nib_zero_a: assert property (!write_n && latch_sel_lo |-> bus_upper_nibble == 4'h0)
      else $error("upper nibble not zero");
   upd_clear_a: assert property (!output_update_n |-> select_n && write_n)
      else $error("update overlaps write");
   upd_width_a: assert property ($fell(output_update_n) |-> ##12 !output_update_n ##1 output_update_n)
      else $error("update pulse width");
   word_rise_a: assert property ($rose(word_write_n) |-> $stable({word_msb, word_low_bits})
      && !(select_chan_a_n && select_chan_b_n))
      else $error("word edge without select or data");
   desel_idle_a: assert property (($rose(select_chan_a_n) || $rose(select_chan_b_n)) |-> word_write_n)
      else $error("select released while write low");
endmodule
bind dual_dac_host dual_dac_host_assertions i_chk (.*);

// *** bench/dual_dac_host_tb_top.sv ***
// testbench for the dual dac host controller
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED %0t got %h", $time, g); end end
module dual_dac_host_tb_top;
   reg clk_sys = 0, srst = 1, clk_en = 1, req_valid = 0, word_mode = 0;
   reg [1:0] chan_mask = 2'h0;
   reg [11:0] code_a = 12'h000, code_b = 12'h000;
   wire req_ready, busy, select_n, write_n, latch_sel_hi, latch_sel_lo, output_update_n;
   wire select_chan_a_n, select_chan_b_n, word_write_n, word_msb;
   wire [3:0] bus_upper_nibble, bus_lower_nibble;
   wire [10:0] word_low_bits;
   wire [11:0] dac_a, dac_b, word_a, word_b;
   int errors = 0, tests_run = 0;
   always #2 clk_sys = ~clk_sys;
   dual_dac_host i_dut (.*);
   dual_dac_model i_dev (.*);
   task results;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one request, then wait bounded for idle
   task send(input m, input [1:0] k, input [11:0] a, input [11:0] b);
      int n;
      word_mode = m;
      chan_mask = k;
      code_a = a;
      code_b = b;
      req_valid = 1;
      @(posedge clk_sys) #1 req_valid = 0;
      for (n = 0; n < 400 && (busy || !req_ready); n++) @(posedge clk_sys) #1;
      if (n == 400) begin errors++; results; end
   endtask
   task t_byte;
      send(0, 2'h3, 12'habc, 12'h5a3);
      `CHK(dac_a, 12'habc)
      `CHK(dac_b, 12'h5a3)
      send(0, 2'h1, 12'h0f1, 12'h777);
      `CHK(dac_a, 12'h0f1)
      `CHK(dac_b, 12'h5a3)
      send(0, 2'h2, 12'h123, 12'h9c6);
      `CHK(dac_a, 12'h0f1)
      `CHK(dac_b, 12'h9c6)
   endtask
   task t_word;
      send(1, 2'h3, 12'h8e1, 12'h8e1);
      `CHK(word_b, 12'h8e1)
      `CHK(word_a, 12'h8e1)
      send(1, 2'h3, 12'h801, 12'h3fe);
      `CHK(word_a, 12'h801)
      `CHK(word_b, 12'h3fe)
      send(1, 2'h2, 12'h111, 12'h0c0);
      `CHK(word_a, 12'h801)
      `CHK(word_b, 12'h0c0)
   endtask
   // clock enable low: nothing is taken and the pins hold
   task t_freeze;
      clk_en = 0;
      word_mode = 0;
      chan_mask = 2'h1;
      req_valid = 1;
      repeat (3) @(posedge clk_sys) #1;
      `CHK(req_ready, 1'b0)
      `CHK(busy, 1'b0)
      `CHK(select_n, 1'b1)
      req_valid = 0;
      clk_en = 1;
      @(posedge clk_sys) #1;
      `CHK(req_ready, 1'b1)
   endtask
   // an empty channel mask must start nothing
   task t_refuse;
      chan_mask = 2'h0;
      req_valid = 1;
      repeat (2) @(posedge clk_sys) #1;
      req_valid = 0;
      `CHK(busy, 1'b0)
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      #1 srst = 0;
      `CHK(select_n, 1'b1)
      t_byte;
      t_word;
      t_freeze;
      t_refuse;
      results;
   end
endmodule

// *** bench/dual_dac_model.sv ***
// behavioural dual dac device on both pin sets
`timescale 1ns/1ps
module dual_dac_model (
   // byte pins
   input wire select_n, write_n, latch_sel_hi, latch_sel_lo, output_update_n,
   input wire [3:0] bus_upper_nibble, bus_lower_nibble,
   // word pins
   input wire select_chan_a_n, select_chan_b_n, word_write_n, word_msb,
   input wire [10:0] word_low_bits,
   // latched codes
   output reg [11:0] dac_a = 12'h000, dac_b = 12'h000, word_a = 12'h000, word_b = 12'h000
);
   reg [11:0] in_a = 12'h000, in_b = 12'h000;
   always @* begin
      if (!select_n && !write_n) begin
         case ({latch_sel_hi, latch_sel_lo})
            2'h0: in_a[7:0] = {bus_upper_nibble, bus_lower_nibble};
            2'h1: in_a[11:8] = bus_lower_nibble;
            2'h2: in_b[7:0] = {bus_upper_nibble, bus_lower_nibble};
            2'h3: in_b[11:8] = bus_lower_nibble;
         endcase
      end
      // latches hold otherwise
      if (!output_update_n) begin
         dac_a = in_a;
         dac_b = in_b;
      end
   end
   always @(posedge word_write_n) begin
      if (!select_chan_a_n) word_a <= {word_msb, word_low_bits};
      if (!select_chan_b_n) word_b <= {word_msb, word_low_bits};
   end
endmodule

// *** rtl/dual_dac_host.v ***
// host controller that loads both dac channels through byte or word pins
// Operation
// - byte mode: select low addresses the part
// - write strobe, select, address load byte
// - low nibble carries bits 3:0 or 11:8
// - word mode: chan a select low selects
// - word mode: chan b select low selects
// - word mode: full word, msb on top
`timescale 1ns/1ps
`include "dual_dac_host_consts.vh"
module dual_dac_host (
   // clock, reset, enable
   input wire clk_sys,
   input wire srst,
   input wire clk_en,
   // user request
   input wire req_valid,
   output wire req_ready,
   input wire word_mode,
   input wire [1:0] chan_mask,
   input wire [11:0] code_a,
   input wire [11:0] code_b,
   output reg busy,
   // byte-wide variant pins
   output reg select_n,
   output reg write_n,
   output reg latch_sel_hi,
   output reg latch_sel_lo,
   output reg [3:0] bus_upper_nibble,
   output reg [3:0] bus_lower_nibble,
   output reg output_update_n,
   // word variant pins
   output reg select_chan_a_n,
   output reg select_chan_b_n,
   output reg word_write_n,
   output reg word_msb,
   output reg [10:0] word_low_bits
);
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_SETUP = 5'h02;
   localparam [4:0] ST_STROBE = 5'h04;
   localparam [4:0] ST_NEXT = 5'h08;
   localparam [4:0] ST_UPDATE = 5'h10;

   // counts cut to the counter width on purpose; the macros are plain integers
   localparam [31:0] SETUP_FULL = `SETUP_CYC;
   localparam [31:0] LOAD_FULL = `LOAD_CYC;
   localparam [`CNT_W-1:0] SETUP_CNT = SETUP_FULL[`CNT_W-1:0];
   localparam [`CNT_W-1:0] LOAD_CNT = LOAD_FULL[`CNT_W-1:0];

   reg [4:0] state;
   reg [`CNT_W-1:0] cnt;
   reg [1:0] step;
   reg mode;
   reg [1:0] mask;
   reg [11:0] ca;
   reg [11:0] cb;

   // byte slot for one write step: low byte or high nibble per channel
   function [7:0] byte_of;
      input [1:0] sel;
      input [11:0] a;
      input [11:0] b;
      begin
         case (sel)
            `SEL_A_LOW: byte_of = a[7:0];
            `SEL_A_HIGH: byte_of = {4'h0, a[11:8]};
            `SEL_B_LOW: byte_of = b[7:0];
            default: byte_of = {4'h0, b[11:8]};
         endcase
      end
   endfunction

   // a step is skipped when its channel is not asked for
   function step_used;
      input [1:0] sel;
      input [1:0] m;
      begin
         step_used = sel[1] ? m[1] : m[0];
      end
   endfunction

   // following byte slot in fixed order: a low, a high, b low, b high
   function [1:0] step_after;
      input [1:0] sel;
      begin
         step_after = sel + 2'h1;
      end
   endfunction

   // word for the first write: channel a unless only b is asked for
   function [11:0] first_word;
      input [1:0] m;
      input [11:0] a;
      input [11:0] b;
      begin
         first_word = m[0] ? a : b;
      end
   endfunction

   wire [7:0] cur_byte = byte_of(step, ca, cb);
   wire [11:0] req_word = first_word(chan_mask, code_a, code_b);
   // not ready while frozen, so a handshake never looks taken while clk_en is low; an empty mask still sees ready
   assign req_ready = (state == ST_IDLE) && !srst && clk_en;

   always @(posedge clk_sys) begin
      if (srst) begin
         state <= ST_IDLE;
         cnt <= {`CNT_W{1'b0}};
         step <= 2'h0;
         mode <= 1'b0;
         mask <= 2'h0;
         ca <= 12'h000;
         cb <= 12'h000;
         busy <= 1'b0;
         select_n <= 1'b1;
         write_n <= 1'b1;
         latch_sel_hi <= 1'b0;
         latch_sel_lo <= 1'b0;
         bus_upper_nibble <= 4'h0;
         bus_lower_nibble <= 4'h0;
         output_update_n <= 1'b1;
         select_chan_a_n <= 1'b1;
         select_chan_b_n <= 1'b1;
         word_write_n <= 1'b1;
         word_msb <= 1'b0;
         word_low_bits <= 11'h000;
      end else if (clk_en) begin
         case (state)
            ST_IDLE: begin
               if (req_valid && chan_mask != 2'h0) begin
                  mode <= word_mode;
                  mask <= chan_mask;
                  ca <= code_a;
                  cb <= code_b;
                  busy <= 1'b1;
                  cnt <= SETUP_CNT;
                  state <= ST_SETUP;
                  if (word_mode) begin
                     // a lone mask selects one channel, both share one word
                     word_msb <= req_word[11];
                     word_low_bits <= req_word[10:0];
                     select_chan_a_n <= ~chan_mask[0];
                     select_chan_b_n <= ~chan_mask[1];
                     word_write_n <= 1'b0;
                  end else begin
                     step <= chan_mask[0] ? `SEL_A_LOW : `SEL_B_LOW;
                  end
               end
            end
            ST_SETUP: begin
               if (!mode) begin
                  select_n <= 1'b0;
                  latch_sel_hi <= step[1];
                  latch_sel_lo <= step[0];
                  bus_upper_nibble <= cur_byte[7:4];
                  bus_lower_nibble <= cur_byte[3:0];
                  write_n <= 1'b0;
               end else begin
                  // second write falls one cycle after b's select; the first fell with the selects in ST_IDLE
                  word_write_n <= 1'b0;
               end
               if (cnt <= 1) begin
                  state <= ST_STROBE;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            ST_STROBE: begin
               // data held past the rising edge: zero hold is met one cycle on
               write_n <= 1'b1;
               word_write_n <= 1'b1;
               state <= ST_NEXT;
            end
            ST_NEXT: begin
               select_n <= 1'b1;
               select_chan_a_n <= 1'b1;
               select_chan_b_n <= 1'b1;
               if (mode && mask == 2'h3 && ca != cb) begin
                  // differing codes need a second word write to channel b
                  mask <= 2'h2;
                  word_msb <= cb[11];
                  word_low_bits <= cb[10:0];
                  // write stays high while a's select rises, so a keeps its word
                  select_chan_b_n <= 1'b0;
                  cnt <= SETUP_CNT;
                  state <= ST_SETUP;
               end else if (!mode && step != `SEL_B_HIGH &&
                            step_used(step_after(step), mask)) begin
                  step <= step_after(step);
                  cnt <= SETUP_CNT;
                  state <= ST_SETUP;
               end else if (!mode) begin
                  output_update_n <= 1'b0;
                  cnt <= LOAD_CNT;
                  state <= ST_UPDATE;
               end else begin
                  busy <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            ST_UPDATE: begin
               // update rises only after select and write are high, no overlap
               if (cnt <= 1) begin
                  output_update_n <= 1'b1;
                  busy <= 1'b0;
                  state <= ST_IDLE;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule

// *** rtl/dual_dac_host_consts.vh ***
// timing counts and selector codes for the dual dac host controller
`ifndef DUAL_DAC_HOST_CONSTS_VH
`define DUAL_DAC_HOST_CONSTS_VH
`define CLK_PERIOD_NS 4
`define T_DATA_SETUP_NS 80
`define T_LOAD_PULSE_NS 50
`define T_WR_PULSE_NS 50
`define SETUP_CYC ((`T_DATA_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOAD_CYC ((`T_LOAD_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WR_CYC ((`T_WR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 6
`define SEL_A_LOW 2'h0
`define SEL_A_HIGH 2'h1
`define SEL_B_LOW 2'h2
`define SEL_B_HIGH 2'h3
`endif
